/* File: rtl/cnv_engine.sv */
// Purpose: walks the command list and moves bytes between register bank and storage
// Assumes: bank read data valid in the cycle the address is presented
// Notes:   one storage access outstanding at a time
`timescale 1ns/100ps
module cnv_engine (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        start_save_i,
   input  wire logic        start_load_i,
   output logic [7:0]       seg_idx_o,
   input  wire logic [7:0]  seg_byte_i,
   output logic [11:0]      bank_addr_o,
   output logic [7:0]       bank_wdata_o,
   output logic             bank_we_o,
   input  wire logic [7:0]  bank_rdata_i,
   output logic             nvm_req_o,
   output logic             nvm_write_o,
   output logic [9:0]       nvm_addr_o,
   output logic [7:0]       nvm_wdata_o,
   input  wire logic [7:0]  nvm_rdata_i,
   input  wire logic        nvm_ack_i,
   input  wire logic        nvm_err_i,
   output logic             busy_o,
   output logic             err_o,
   output logic             done_o,
   output logic             update_o
);
   typedef enum logic [2:0] {S_IDLE, S_CMD, S_AHI, S_ALO, S_ISSUE, S_WAIT, S_NEXT} cnv_state_t;

   cnv_state_t  state,    next_state;
   logic        save,     next_save;
   logic [7:0]  idx,      next_idx;
   logic [6:0]  cnt,      next_cnt;
   logic [11:0] addr,     next_addr;
   logic [9:0]  nptr,     next_nptr;
   logic [7:0]  wdata,    next_wdata;
   logic        req,      next_req;
   logic        bwe,      next_bwe;
   logic        err,      next_err;
   logic        done,     next_done;
   logic        upd,      next_upd;

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_save  = save;
      next_idx   = idx;
      next_cnt   = cnt;
      next_addr  = addr;
      next_nptr  = nptr;
      next_wdata = wdata;
      next_req   = 1'b0;
      next_bwe   = 1'b0;
      next_err   = err;
      next_done  = 1'b0;
      next_upd   = 1'b0;
      case (state)
         S_IDLE: begin
            if (start_save_i || start_load_i) begin
               next_save  = start_save_i;
               next_idx   = 8'h00;
               next_nptr  = 10'h000;
               next_err   = 1'b0;
               next_state = S_CMD;
            end
         end
         S_CMD: begin
            if (!seg_byte_i[cnv_pkg::BIT_OPCODE]) begin
               next_cnt   = seg_byte_i[6:0];
               next_idx   = idx + 8'h01;
               next_state = S_AHI;
            end else if (seg_byte_i == cnv_pkg::OP_UPDATE) begin
               next_upd   = 1'b1;
               next_idx   = idx + 8'h01;
               // with no end code, an update code in the last slot stops the walk rather than wrapping
               if (idx == cnv_pkg::SEG_LAST_IDX) begin
                  next_done  = 1'b1;
                  next_state = S_IDLE;
               end
            end else begin
               next_done  = 1'b1;
               next_state = S_IDLE;
            end
         end
         S_AHI: begin
            next_addr[11:8] = seg_byte_i[3:0];
            next_idx        = idx + 8'h01;
            next_state      = S_ALO;
         end
         S_ALO: begin
            next_addr[7:0] = seg_byte_i;
            next_idx       = idx + 8'h01;
            next_state     = S_ISSUE;
         end
         S_ISSUE: begin
            next_wdata = bank_rdata_i;
            next_req   = 1'b1;
            next_state = S_WAIT;
         end
         S_WAIT: begin
            next_req = ~nvm_ack_i;
            if (nvm_ack_i) begin
               if (nvm_err_i) begin
                  next_err = 1'b1;
               end
               if (!save) begin
                  next_wdata = nvm_rdata_i;
                  next_bwe   = 1'b1;
               end
               next_nptr  = nptr + 10'h001;
               next_state = S_NEXT;
            end
         end
         // address steps in S_NEXT, on the same edge that writes a loaded byte into the bank at the old address
         S_NEXT: begin
            if (cnt == 7'h00) begin
               next_state = S_CMD;
            end else begin
               next_cnt   = cnt - 7'h01;
               next_addr  = addr + 12'h001;
               next_state = S_ISSUE;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= S_IDLE;
         save  <= 1'b0;
         idx   <= 8'h00;
         cnt   <= 7'h00;
         addr  <= 12'h000;
         nptr  <= 10'h000;
         wdata <= 8'h00;
         req   <= 1'b0;
         bwe   <= 1'b0;
         err   <= 1'b0;
         done  <= 1'b0;
         upd   <= 1'b0;
      end else begin
         state <= next_state;
         save  <= next_save;
         idx   <= next_idx;
         cnt   <= next_cnt;
         addr  <= next_addr;
         nptr  <= next_nptr;
         wdata <= next_wdata;
         req   <= next_req;
         bwe   <= next_bwe;
         err   <= next_err;
         done  <= next_done;
         upd   <= next_upd;
      end
   end

   // bank write lands one cycle after the load ack, at the address then current
   assign seg_idx_o    = idx;
   assign bank_addr_o  = addr;
   assign bank_wdata_o = wdata;
   assign bank_we_o    = bwe;
   assign nvm_req_o    = req;
   assign nvm_write_o  = save;
   assign nvm_addr_o   = nptr;
   assign nvm_wdata_o  = wdata;
   assign busy_o       = (state != S_IDLE) || bwe;
   assign err_o        = err;
   assign done_o       = done;
   assign update_o     = upd;
endmodule

/* File: rtl/cnv_pkg.sv */
// Purpose: shared constants for the configuration nonvolatile save/restore control
// Assumes: 8-bit register data, 12-bit register addresses
// Notes:   opcode values and segment reset fill are plain defaults
package cnv_pkg;
   localparam int          ADDR_W         = 12;
   localparam int          DATA_W         = 8;
   localparam int          NVM_AW         = 10;
   // --------------------------------------------------------------
   // register offsets
   // --------------------------------------------------------------
   localparam logic [11:0] OFS_STATUS_PIN = 12'h01D;
   localparam logic [11:0] OFS_UPDATE     = 12'h232;
   localparam logic [11:0] OFS_SEG_BASE   = 12'hA00;
   localparam logic [11:0] OFS_SEG_LAST   = 12'hAFF;
   localparam logic [11:0] OFS_XFER_STAT  = 12'hB00;
   localparam logic [11:0] OFS_DATA_ERR   = 12'hB01;
   localparam logic [11:0] OFS_CONTROL    = 12'hB02;
   localparam logic [11:0] OFS_SAVE_TRIG  = 12'hB03;
   // --------------------------------------------------------------
   // field positions
   // --------------------------------------------------------------
   localparam int          BIT_BUSY       = 0;
   localparam int          BIT_ERR        = 0;
   localparam int          BIT_WR_EN      = 0;
   localparam int          BIT_SOFT_LOAD  = 1;
   localparam int          BIT_SAVE       = 0;
   localparam int          BIT_UPDATE     = 0;
   localparam int          BIT_PIN_SEL    = 7;
   localparam int          BIT_OPCODE     = 7;
   // --------------------------------------------------------------
   // reset values and command codes
   // --------------------------------------------------------------
   localparam logic        RST_WR_EN      = 1'b0;
   localparam logic        RST_PIN_SEL    = 1'b0;
   localparam logic [7:0]  OP_UPDATE      = 8'hA0;
   localparam logic [7:0]  OP_END         = 8'hFF;
   localparam logic [7:0]  RST_SEG_BYTE   = 8'hFF;
   localparam logic [7:0]  SEG_LAST_IDX   = 8'hFF;
   // --------------------------------------------------------------
   // timing
   // --------------------------------------------------------------
   localparam int          CLK_MHZ        = 125;
   localparam int          T_GAP_US       = 10;
   localparam int          GAP_CYCLES     = T_GAP_US * CLK_MHZ;
endpackage

/* File: rtl/cnv_ctrl.sv */
// Purpose: register file and control for configuration save/restore to nonvolatile storage
// Assumes: register port comes from the serial control port decoder on ref_clk_i
// Notes:   the host keeps the 10 us gap between transfers; nothing here enforces it
//
// Operation
// - busy flag bit 0 of transfer status reads 1 while a transfer runs.
// - with pin source select set, status pin shows the busy flag.
// - error flag bit 0 reads 1 when bad data was seen during transfer.
// - with boot pin low, writing control bit 1 reloads stored settings; self-clears.
// - write permission resets to 0 and then storage stays write-protected.
// - write permission at 1 lets the host write storage.
// - writing 1 to save trigger bit 0 starts copying buffer into storage.
// - save trigger bit clears itself when the copy has completed.
// - command bit 7 low means transfer: count minus one, then address MSB first.
// - command bit 7 high is an opcode: update active registers, or end.
// - writing 1 to update bit copies buffer to active registers next edge.
`timescale 1ns/100ps
module cnv_ctrl (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic [11:0] reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_we_i,
   input  wire logic        reg_re_i,
   output logic [7:0]       reg_rdata_o,
   input  wire logic        boot_src_n_i,
   input  wire logic        status_alt_i,
   output logic             status_pin_o,
   output logic             soft_reset_o,
   output logic             update_o,
   output logic [11:0]      bank_addr_o,
   output logic [7:0]       bank_wdata_o,
   output logic             bank_we_o,
   input  wire logic [7:0]  bank_rdata_i,
   output logic             nvm_req_o,
   output logic             nvm_write_o,
   output logic [9:0]       nvm_addr_o,
   output logic [7:0]       nvm_wdata_o,
   input  wire logic [7:0]  nvm_rdata_i,
   input  wire logic        nvm_ack_i,
   input  wire logic        nvm_err_i
);
   // --------------------------------------------------------------
   // decode helpers
   // --------------------------------------------------------------
   function automatic logic cnv_is_seg(input logic [11:0] a);
      cnv_is_seg = (a >= cnv_pkg::OFS_SEG_BASE) && (a <= cnv_pkg::OFS_SEG_LAST);
   endfunction

   logic [7:0]  seg [256];
   logic [7:0]  next_seg [256];
   logic        wr_en,      next_wr_en;
   logic        pin_sel,    next_pin_sel;
   logic        save_trig,  next_save_trig;
   logic        soft_pulse, next_soft_pulse;
   logic        upd_pulse,  next_upd_pulse;
   logic [7:0]  rdata,      next_rdata;
   logic        boot_meta;
   logic        boot_sync;
   logic        start_save;
   logic        start_load;
   logic [7:0]  seg_idx;
   logic        busy;
   logic        err;
   logic        done;
   logic        eng_upd;

   // --------------------------------------------------------------
   // boot pin synchroniser
   // --------------------------------------------------------------
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         boot_meta <= 1'b1;
         boot_sync <= 1'b1;
      end else begin
         boot_meta <= boot_src_n_i;
         boot_sync <= boot_meta;
      end
   end

   // --------------------------------------------------------------
   // register writes
   // --------------------------------------------------------------
   // a new transfer is refused while one runs, so a stray trigger cannot corrupt it
   assign start_save = reg_we_i && (reg_addr_i == cnv_pkg::OFS_SAVE_TRIG)
                       && reg_wdata_i[cnv_pkg::BIT_SAVE] && wr_en && !busy;
   assign start_load = reg_we_i && (reg_addr_i == cnv_pkg::OFS_CONTROL)
                       && reg_wdata_i[cnv_pkg::BIT_SOFT_LOAD] && !boot_sync && !busy;

   always_comb begin
      next_seg        = seg;
      next_wr_en      = wr_en;
      next_pin_sel    = pin_sel;
      next_soft_pulse = start_load;
      next_upd_pulse  = 1'b0;
      if (done) begin
         next_save_trig = 1'b0;
      end else begin
         next_save_trig = save_trig;
      end
      if (start_save) begin
         next_save_trig = 1'b1;
      end
      if (reg_we_i) begin
         if (cnv_is_seg(reg_addr_i)) begin
            next_seg[reg_addr_i[7:0]] = reg_wdata_i;
         end
         if (reg_addr_i == cnv_pkg::OFS_CONTROL) begin
            next_wr_en = reg_wdata_i[cnv_pkg::BIT_WR_EN];
         end
         if (reg_addr_i == cnv_pkg::OFS_STATUS_PIN) begin
            next_pin_sel = reg_wdata_i[cnv_pkg::BIT_PIN_SEL];
         end
         if (reg_addr_i == cnv_pkg::OFS_UPDATE) begin
            next_upd_pulse = reg_wdata_i[cnv_pkg::BIT_UPDATE];
         end
      end
   end

   // --------------------------------------------------------------
   // register reads
   // --------------------------------------------------------------
   always_comb begin
      next_rdata = rdata;
      if (reg_re_i) begin
         next_rdata = 8'h00;
         if (cnv_is_seg(reg_addr_i)) begin
            next_rdata = seg[reg_addr_i[7:0]];
         end
         case (reg_addr_i)
            cnv_pkg::OFS_XFER_STAT:  next_rdata[cnv_pkg::BIT_BUSY]    = busy;
            cnv_pkg::OFS_DATA_ERR:   next_rdata[cnv_pkg::BIT_ERR]     = err;
            cnv_pkg::OFS_CONTROL:    next_rdata[cnv_pkg::BIT_WR_EN]   = wr_en;
            cnv_pkg::OFS_SAVE_TRIG:  next_rdata[cnv_pkg::BIT_SAVE]    = save_trig;
            cnv_pkg::OFS_STATUS_PIN: next_rdata[cnv_pkg::BIT_PIN_SEL] = pin_sel;
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 256; i++) begin
            seg[i] <= cnv_pkg::RST_SEG_BYTE;
         end
         wr_en      <= cnv_pkg::RST_WR_EN;
         pin_sel    <= cnv_pkg::RST_PIN_SEL;
         save_trig  <= 1'b0;
         soft_pulse <= 1'b0;
         upd_pulse  <= 1'b0;
         rdata      <= 8'h00;
      end else begin
         seg        <= next_seg;
         wr_en      <= next_wr_en;
         pin_sel    <= next_pin_sel;
         save_trig  <= next_save_trig;
         soft_pulse <= next_soft_pulse;
         upd_pulse  <= next_upd_pulse;
         rdata      <= next_rdata;
      end
   end

   // --------------------------------------------------------------
   // transfer engine
   // --------------------------------------------------------------
   cnv_engine u_engine (
      .ref_clk_i    (ref_clk_i),
      .rst_i        (rst_i),
      .start_save_i (start_save),
      .start_load_i (start_load),
      .seg_idx_o    (seg_idx),
      .seg_byte_i   (seg[seg_idx]),
      .bank_addr_o  (bank_addr_o),
      .bank_wdata_o (bank_wdata_o),
      .bank_we_o    (bank_we_o),
      .bank_rdata_i (bank_rdata_i),
      .nvm_req_o    (nvm_req_o),
      .nvm_write_o  (nvm_write_o),
      .nvm_addr_o   (nvm_addr_o),
      .nvm_wdata_o  (nvm_wdata_o),
      .nvm_rdata_i  (nvm_rdata_i),
      .nvm_ack_i    (nvm_ack_i),
      .nvm_err_i    (nvm_err_i),
      .busy_o       (busy),
      .err_o        (err),
      .done_o       (done),
      .update_o     (eng_upd)
   );

   assign reg_rdata_o  = rdata;
   assign status_pin_o = pin_sel ? busy : status_alt_i;
   assign soft_reset_o = soft_pulse;
   assign update_o     = upd_pulse | eng_upd;
endmodule

/* File: tb/cnv_nvm_model.sv */
// Purpose: storage partner on the nvm request port
// Assumes: one request outstanding, ack ends it
// Notes:   read data off the ack cycle shows the inverse of the last value
`timescale 1ns/100ps
module cnv_nvm_model (
   input  wire logic       ref_clk_i,
   input  wire logic       req_i,
   input  wire logic       write_i,
   input  wire logic [9:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic [3:0] dly_i,
   input  wire logic       bad_i,
   output logic [7:0]      rdata_o,
   output logic            ack_o,
   output logic            err_o
);
   logic [7:0] mem [0:1023];
   logic [7:0] last = 8'h00;
   int         cnt  = 0;
   initial begin
      ack_o = 1'b0;
      err_o = 1'b0;
      rdata_o = 8'hFF;
   end
   // slow answers come from dly_i; err_o follows bad_i on the ack cycle and shows ~bad_i off it
   always @(posedge ref_clk_i) begin
      #1;
      if (ack_o) begin
         ack_o = 1'b0;
         err_o = ~bad_i;
         rdata_o = ~last;
         cnt = 0;
      end else if (req_i) begin
         if (cnt >= dly_i) begin
            ack_o = 1'b1;
            err_o = bad_i;
            if (write_i) mem[addr_i] = wdata_i;
            else last = mem[addr_i];
            rdata_o = write_i ? ~last : last;
         end else cnt++;
      end
   end
endmodule

/* File: tb/cnv_ctrl_chk.sv */
// Purpose: port-level checks for the save/restore control
// Assumes: single clock domain, async reset
// Notes:   select and write-enable mirrored from register writes
`timescale 1ns/100ps
module cnv_ctrl_chk (
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic        reg_we_i,
   input wire logic        reg_re_i,
   input wire logic [7:0]  reg_rdata_o,
   input wire logic        status_alt_i,
   input wire logic        status_pin_o,
   input wire logic        soft_reset_o,
   input wire logic        update_o,
   input wire logic        bank_we_o,
   input wire logic        nvm_req_o,
   input wire logic        nvm_write_o,
   input wire logic [9:0]  nvm_addr_o,
   input wire logic        nvm_ack_i
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   logic sel;
   logic wen;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sel <= 1'b0;
         wen <= 1'b0;
      end else if (reg_we_i && reg_addr_i == 12'h01D) sel <= reg_wdata_i[7];
      else if (reg_we_i && reg_addr_i == 12'hB02) wen <= reg_wdata_i[0];
   end
   a_pin_alt_path: assert property (!sel |-> status_pin_o == status_alt_i)
      else $error("status pin not showing other source");
   a_pin_busy_path: assert property (sel && nvm_req_o |-> status_pin_o)
      else $error("status pin low during transfer");
   a_req_held: assert property (nvm_req_o && !nvm_ack_i |=> nvm_req_o && $stable(nvm_addr_o))
      else $error("storage request dropped before ack");
   a_ack_drops_req: assert property (nvm_ack_i |=> !nvm_req_o)
      else $error("request still up after ack");
   a_save_needs_wen: assert property (nvm_req_o && nvm_write_o |-> wen)
      else $error("storage written while protected");
   a_wp_no_start: assert property (reg_we_i && reg_addr_i == 12'hB03 && reg_wdata_i[0] && !wen
      && !nvm_req_o |=> !nvm_req_o [*8])
      else $error("protected save trigger started a transfer");
   a_soft_one_shot: assert property (soft_reset_o |-> $past(reg_we_i && reg_addr_i == 12'hB02
      && reg_wdata_i[1]) ##1 !soft_reset_o)
      else $error("soft reload pulse without its write");
   a_update_next: assert property (reg_we_i && reg_addr_i == 12'h232 && reg_wdata_i[0] |=> update_o)
      else $error("update pulse missing");
   a_bank_we_ack: assert property (bank_we_o |-> $past(nvm_ack_i && !nvm_write_o))
      else $error("bank write without a read ack");
   a_rdata_holds: assert property (!$past(reg_re_i) |-> $stable(reg_rdata_o))
      else $error("read data moved without a read");
endmodule
bind cnv_ctrl cnv_ctrl_chk chk_u (.*);

/* File: tb/cnv_ctrl_tb.sv */
// Purpose: self-checking bench for the save/restore control
// Assumes: bank modelled here as a flat array
// Notes:   the 10 us gap is kept by the bench, the design does not enforce it
`timescale 1ns/100ps
module cnv_ctrl_tb;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [11:0] reg_addr_i = 12'h000;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic        reg_we_i = 1'b0;
   logic        reg_re_i = 1'b0;
   logic        boot_src_n_i = 1'b1;
   logic        status_alt_i = 1'b0;
   logic [3:0]  dly = 4'h0;
   logic        bad = 1'b0;
   logic [7:0]  reg_rdata_o, bank_wdata_o, nvm_wdata_o, nvm_rdata_i, rd;
   logic [11:0] bank_addr_o;
   logic [9:0]  nvm_addr_o;
   logic        status_pin_o, soft_reset_o, update_o, bank_we_o;
   logic        nvm_req_o, nvm_write_o, nvm_ack_i, nvm_err_i;
   logic [7:0]  bank [0:4095];
   int          bad_count = 0, checked = 0, upd_n = 0, srst_n = 0;
   wire  [7:0]  bank_rdata_i = bank[bank_addr_o];
   cnv_ctrl dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
      .boot_src_n_i(boot_src_n_i), .status_alt_i(status_alt_i), .status_pin_o(status_pin_o),
      .soft_reset_o(soft_reset_o), .update_o(update_o), .bank_addr_o(bank_addr_o),
      .bank_wdata_o(bank_wdata_o), .bank_we_o(bank_we_o), .bank_rdata_i(bank_rdata_i),
      .nvm_req_o(nvm_req_o), .nvm_write_o(nvm_write_o), .nvm_addr_o(nvm_addr_o),
      .nvm_wdata_o(nvm_wdata_o), .nvm_rdata_i(nvm_rdata_i), .nvm_ack_i(nvm_ack_i), .nvm_err_i(nvm_err_i));
   cnv_nvm_model nvm_u (.ref_clk_i(ref_clk_i), .req_i(nvm_req_o), .write_i(nvm_write_o),
      .addr_i(nvm_addr_o), .wdata_i(nvm_wdata_o), .dly_i(dly), .bad_i(bad),
      .rdata_o(nvm_rdata_i), .ack_o(nvm_ack_i), .err_o(nvm_err_i));
   always #4 ref_clk_i = ~ref_clk_i;
   initial for (int i = 0; i < 4096; i++) bank[i] = 8'h00;
   always @(posedge ref_clk_i) begin
      if (bank_we_o === 1'b1) bank[bank_addr_o] <= bank_wdata_o;
      if (update_o === 1'b1) upd_n++;
      if (soft_reset_o === 1'b1) srst_n++;
   end
   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task automatic step();
      @(posedge ref_clk_i);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      step();
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_we_i = 1'b1;
      step();
      reg_we_i = 1'b0;
   endtask
   task automatic rd_reg(input logic [11:0] a);
      step();
      reg_addr_i = a;
      reg_re_i = 1'b1;
      step();
      reg_re_i = 1'b0;
      rd = reg_rdata_o;
   endtask
   task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
      rd_reg(a);
      chk(rd, exp);
   endtask
   // polls busy under a bounded count; a hang counts as a mismatch
   task automatic wait_idle();
      for (int n = 0; n < 300; n++) begin
         rd_reg(12'hB00);
         chk(rd & 8'hFE, 8'h00);
         if (rd === 8'h00) return;
      end
      chk(rd, 8'h00);
   endtask
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      status_alt_i = 1'b1;
      rchk(12'hB00, 8'h00);
      rchk(12'hB01, 8'h00);
      rchk(12'hB02, 8'h00);
      rchk(12'hB03, 8'h00);
      rchk(12'h555, 8'h00);
      rchk(12'hAFF, 8'hFF);
      chk({7'h00, status_pin_o}, 8'h01);
   endtask
   task automatic t_protect();
      wr(12'hB03, 8'h01);
      rchk(12'hB00, 8'h00);
      rchk(12'hB03, 8'h00);
   endtask
   task automatic t_save();
      bank[12'h100] = 8'h5A;
      bank[12'h101] = 8'hC3;
      wr(12'hA00, 8'h01);
      wr(12'hA01, 8'h01);
      wr(12'hA02, 8'h00);
      wr(12'hA03, 8'hA0);
      wr(12'hA04, 8'hFF);
      dly = 4'h6;
      wr(12'h01D, 8'h80);
      wr(12'hB02, 8'h01);
      wr(12'hB03, 8'h01);
      rchk(12'hB00, 8'h01);
      rchk(12'hB03, 8'h01);
      chk({7'h00, status_pin_o}, 8'h01);
      wait_idle();
      chk({7'h00, status_pin_o}, 8'h00);
      chk(nvm_u.mem[0], 8'h5A);
      chk(nvm_u.mem[1], 8'hC3);
      rchk(12'hB03, 8'h00);
      rchk(12'hB01, 8'h00);
      chk(8'(upd_n), 8'h01);
      repeat (1250) step();
   endtask
   task automatic t_load();
      dly = 4'h0;
      bad = 1'b1;
      bank[12'h100] = 8'h00;
      bank[12'h101] = 8'h00;
      wr(12'hB02, 8'h03);
      step();
      chk(8'(srst_n), 8'h00);
      boot_src_n_i = 1'b0;
      repeat (3) step();
      wr(12'hB02, 8'h03);
      step();
      chk(8'(srst_n), 8'h01);
      wait_idle();
      chk(bank[12'h100], 8'h5A);
      chk(bank[12'h101], 8'hC3);
      rchk(12'hB01, 8'h01);
      rchk(12'hB02, 8'h01);
      chk(8'(upd_n), 8'h02);
      bad = 1'b0;
      repeat (1250) step();
   endtask
   task automatic t_update();
      wr(12'h232, 8'h01);
      step();
      chk(8'(upd_n), 8'h03);
   endtask
   task automatic stop_test();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
   initial begin
      repeat (10) @(posedge ref_clk_i);
      #1;
      rst_i = 1'b0;
      t_reset();
      t_protect();
      t_save();
      t_load();
      t_update();
      stop_test();
   end
endmodule
